// *** hw/idd_pkg.sv ***
package idd_pkg;
  // condition code that makes the transfer unconditional
  localparam logic [4:0] COND_ALWAYS = 5'h1F;
  // second element address offsets
  localparam logic [31:0] K_NW = 32'h0000_0001;
  localparam logic [31:0] K_SW = 32'h0000_0002;
  localparam logic [31:0] K_BW = 32'h0000_0004;
  localparam logic [31:0] K_BCAST = 32'h0000_0000;
  // index number inside each generator that has a broadcast bit
  localparam logic [2:0] BCAST_IDX = 3'h1;
  // register port map
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h4;
  // event bit positions
  localparam int EV_SPACE = 0;
  localparam int EV_OPT = 1;
  localparam int EV_DONE = 2;
  localparam int EV_W = 3;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [3:0] BE_BYTE = 4'h1;
  localparam logic [3:0] BE_SHORT = 4'h3;
  localparam logic [3:0] BE_WORD = 4'hF;
  localparam logic [7:0] JUST_PAD = 8'h00;

  typedef enum logic [1:0] {
    FORM_4A = 2'b00,
    FORM_4B = 2'b01,
    FORM_4D = 2'b10
  } idd_form_t;

  typedef enum logic [1:0] {
    SZ_NW = 2'b00,
    SZ_SW = 2'b01,
    SZ_BW = 2'b10
  } idd_size_t;

  // opt = {short, sign extend, normal word}
  typedef struct packed {
    idd_form_t form;
    logic [4:0] cond;
    logic g;
    logic d;
    logic u;
    logic [3:0] dreg;
    logic [2:0] idx;
    logic [5:0] imm;
    logic [2:0] opt;
  } idd_instr_t;

  typedef struct packed {
    logic valid;
    logic pm;
    logic wr;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } idd_mem_t;

  typedef struct packed {
    logic valid;
    logic g;
    logic [2:0] idx;
    logic [31:0] value;
  } idd_idx_t;

  typedef struct packed {
    logic valid;
    logic [3:0] dreg;
    logic [39:0] data;
  } idd_wb_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } idd_regbus_t;

  typedef struct packed {
    idd_mem_t mem_x;
    idd_mem_t mem_y;
    idd_idx_t idx_upd;
    logic comp_x;
    logic comp_y;
    idd_size_t ld_size;
    logic ld_sext;
    logic [3:0] ld_dreg;
    logic pend_x;
    logic pend_y;
    idd_size_t pend_size;
    logic pend_sext;
    logic [3:0] pend_dreg;
    idd_wb_t wb_x;
    idd_wb_t wb_y;
    logic [2:0] status;
    logic [2:0] mask;
    logic [31:0] rdata;
  } idd_state_t;
endpackage

// *** hw/idd_decode.sv ***
// Function
// [RULE_01] g picks dm/first or pm/second index, d load/store, u pre/post.
// [RULE_02] condition all ones is unconditional; else gates whole access.
// [RULE_03] address is index plus immediate, or index then index updated.
// [RULE_04] pre-modify leaves the index register untouched.
// [RULE_05] each element checks its own condition and acts alone.
// [RULE_06] second element adds 1, 2 or 4 before modify.
// [RULE_07] broadcast bits for index 1 or 9 give second element offset 0.
// [RULE_08] second element uses complementary data register, same number.
// [RULE_09] compute form runs compute beside access; other forms have none.
// [RULE_10] 48-bit form carries sub-word options and no compute.
// [RULE_11] byte loads zero-extend, byte stores write low 8 bits.
// [RULE_12] short loads zero-extend, short stores write low 16 bits.
// [RULE_13] sign-extending options only on loads, extending the sign bit.
// [RULE_14] sub-word access outside byte space raises interrupt, no access.
// [RULE_15] sub-word load left-justified in 40 bits, bits 7..0 cleared.
// [RULE_16] short load: lower byte address is the low byte.
// [RULE_17] sub-word index update scales immediate by access size.
// [RULE_18] each element tests its own arithmetic status register.
// [RULE_19] no-compute form: loads take sign options, stores narrower field.
module idd_decode (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_valid,
  input wire idd_pkg::idd_instr_t i_instr,
  input wire logic [31:0] i_index,
  input wire logic i_byte_space,
  input wire logic i_simd,
  input wire logic i_broadcast_read_first_index,
  input wire logic i_broadcast_read_ninth_index,
  input wire logic [31:0] i_arith_status_first_pe,
  input wire logic [31:0] i_arith_status_second_pe,
  input wire logic [39:0] i_dreg_x,
  input wire logic [39:0] i_dreg_y,
  input wire logic [31:0] i_mem_rd_x,
  input wire logic [31:0] i_mem_rd_y,
  input wire idd_pkg::idd_regbus_t i_reg,
  output logic [31:0] o_reg_rdata,
  output idd_pkg::idd_mem_t o_mem_x,
  output idd_pkg::idd_mem_t o_mem_y,
  output idd_pkg::idd_idx_t o_idx_upd,
  output idd_pkg::idd_wb_t o_wb_x,
  output idd_pkg::idd_wb_t o_wb_y,
  output logic o_comp_x,
  output logic o_comp_y,
  output logic o_irq
);
  import idd_pkg::*;

  idd_state_t state;
  idd_state_t next_state;

  idd_size_t size;
  logic sext;
  logic sub;
  logic space_bad;
  logic opt_bad;
  logic go;
  logic cx;
  logic cy;
  logic ex;
  logic ey;
  logic bcast;
  logic [31:0] imm_s;
  logic [31:0] mod;
  logic [31:0] addr;
  logic [31:0] kk;
  logic [31:0] sval_x;
  logic [31:0] sval_y;
  logic [3:0] be;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;

  function automatic logic cond_true(input logic [31:0] st,
                                     input logic [4:0] c);
    logic r;
    r = (c == COND_ALWAYS) | (st[c[3:0]] ^ c[4]);
    return r;
  endfunction

  function automatic logic [39:0] load_fmt(input logic [31:0] rd,
                                           input idd_size_t sz,
                                           input logic se);
    logic [31:0] v;
    case (sz)
      SZ_BW: v = {{24{se & rd[7]}}, rd[7:0]}; // [RULE_11] [RULE_13]
      // lane 0 holds the lower byte address
      SZ_SW: v = {{16{se & rd[15]}}, rd[15:8], rd[7:0]}; // [RULE_12] [RULE_16]
      default: v = rd;
    endcase
    return {v, JUST_PAD}; // [RULE_15]
  endfunction

  function automatic logic [31:0] store_fmt(input logic [39:0] r,
                                            input idd_size_t sz);
    logic [31:0] v;
    case (sz)
      SZ_BW: v = {24'h000000, r[15:8]}; // [RULE_11]
      SZ_SW: v = {16'h0000, r[23:8]}; // [RULE_12]
      default: v = r[39:8];
    endcase
    return v;
  endfunction

  // 4a is always a full word; 4d always sub-word
  always_comb
  begin
    case (i_instr.form)
      FORM_4B: size = i_instr.opt[0] ? SZ_NW
                    : (i_instr.opt[2] ? SZ_SW : SZ_BW); // [RULE_19]
      FORM_4D: size = i_instr.opt[2] ? SZ_SW : SZ_BW; // [RULE_10]
      default: size = SZ_NW;
    endcase
  end

  assign sub = (size != SZ_NW);
  assign sext = sub & i_instr.opt[1];
  assign opt_bad = sext & i_instr.d; // [RULE_13] [RULE_19]
  assign space_bad = sub & ~i_byte_space; // [RULE_14]
  assign go = i_valid & ~space_bad & ~opt_bad;
  assign cx = cond_true(i_arith_status_first_pe, i_instr.cond); // [RULE_18]
  assign cy = i_simd
            & cond_true(i_arith_status_second_pe, i_instr.cond); // [RULE_18]
  assign ex = go & cx; // [RULE_02] [RULE_05]
  assign ey = go & cy; // [RULE_05]
  assign imm_s = {{26{i_instr.imm[5]}}, i_instr.imm};
  assign mod = (size == SZ_SW) ? {imm_s[30:0], 1'b0} : imm_s; // [RULE_17]
  assign addr = i_instr.u ? i_index : i_index + mod; // [RULE_03]
  assign bcast = ~i_instr.d & (i_instr.idx == BCAST_IDX)
               & (i_instr.g ? i_broadcast_read_ninth_index
                            : i_broadcast_read_first_index); // [RULE_07]

  always_comb
  begin
    case (size)
      SZ_SW: kk = K_SW;
      SZ_BW: kk = K_BW;
      default: kk = K_NW;
    endcase
    if (bcast)
    begin
      kk = K_BCAST; // [RULE_07]
    end
  end

  always_comb
  begin
    case (size)
      SZ_SW: be = BE_SHORT;
      SZ_BW: be = BE_BYTE;
      default: be = BE_WORD;
    endcase
  end

  assign sval_x = store_fmt(i_dreg_x, size);
  assign sval_y = store_fmt(i_dreg_y, size); // [RULE_08]

  // events; set beats a same-cycle write-one clear
  assign ev = {ex | ey, i_valid & opt_bad, i_valid & space_bad}; // [RULE_14]
  assign clr = (i_reg.wr && i_reg.addr == REG_STATUS)
             ? i_reg.wdata[EV_W-1:0] : '0;

  always_comb
  begin
    next_state = state;
    next_state.mem_x.valid = ex; // [RULE_02]
    next_state.mem_x.pm = i_instr.g; // [RULE_01]
    next_state.mem_x.wr = i_instr.d; // [RULE_01]
    next_state.mem_x.addr = addr; // [RULE_03]
    next_state.mem_x.be = be;
    next_state.mem_x.wdata = sval_x;
    next_state.mem_y.valid = ey; // [RULE_05]
    next_state.mem_y.pm = i_instr.g;
    next_state.mem_y.wr = i_instr.d;
    // offset added to the first element address, so both forms share it
    next_state.mem_y.addr = addr + kk; // [RULE_06]
    next_state.mem_y.be = be;
    next_state.mem_y.wdata = sval_y;
    // post-modify only; pre-modify never writes the index back
    next_state.idx_upd.valid = i_instr.u & (ex | ey); // [RULE_03] [RULE_04]
    next_state.idx_upd.g = i_instr.g;
    next_state.idx_upd.idx = i_instr.idx;
    next_state.idx_upd.value = i_index + mod; // [RULE_17]
    next_state.comp_x = ex & (i_instr.form == FORM_4A); // [RULE_09]
    next_state.comp_y = ey & (i_instr.form == FORM_4A); // [RULE_09]
    next_state.ld_size = size;
    next_state.ld_sext = sext;
    next_state.ld_dreg = i_instr.dreg;
    next_state.pend_x = state.mem_x.valid & ~state.mem_x.wr;
    next_state.pend_y = state.mem_y.valid & ~state.mem_y.wr;
    next_state.pend_size = state.ld_size;
    next_state.pend_sext = state.ld_sext;
    next_state.pend_dreg = state.ld_dreg;
    next_state.wb_x.valid = state.pend_x;
    next_state.wb_x.dreg = state.pend_dreg;
    next_state.wb_x.data = load_fmt(i_mem_rd_x, state.pend_size,
                                    state.pend_sext); // [RULE_15]
    next_state.wb_y.valid = state.pend_y;
    next_state.wb_y.dreg = state.pend_dreg; // [RULE_08]
    next_state.wb_y.data = load_fmt(i_mem_rd_y, state.pend_size,
                                    state.pend_sext);
    next_state.status = (state.status & ~clr) | ev;
    if (i_reg.wr && i_reg.addr == REG_MASK)
    begin
      next_state.mask = i_reg.wdata[EV_W-1:0];
    end
    next_state.rdata = '0;
    if (i_reg.rd)
    begin
      case (i_reg.addr)
        REG_STATUS: next_state.rdata = {29'h0, state.status};
        REG_MASK: next_state.rdata = {29'h0, state.mask};
        default: next_state.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      state <= '0;
      state.status <= STATUS_RST;
      state.mask <= MASK_RST;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_mem_x = state.mem_x;
  assign o_mem_y = state.mem_y;
  assign o_idx_upd = state.idx_upd;
  assign o_wb_x = state.wb_x;
  assign o_wb_y = state.wb_y;
  assign o_comp_x = state.comp_x;
  assign o_comp_y = state.comp_y;
  assign o_reg_rdata = state.rdata;
  assign o_irq = |(state.status & state.mask);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_load_issue;
    ex && !i_instr.d;
  endsequence

  sequence s_load_back;
    ##3 o_wb_x.valid && o_wb_x.data[7:0] == 8'h00;
  endsequence

  a_uncond_issue: assert property ( // [RULE_02]
    go && i_instr.cond == COND_ALWAYS |=> o_mem_x.valid)
    else $error("unconditional access not issued");

  a_cond_block: assert property ( // [RULE_05]
    i_valid && !cx |=> !o_mem_x.valid)
    else $error("first element acted on false condition");

  a_post_addr: assert property ( // [RULE_03]
    ex && i_instr.u |=> o_mem_x.addr == $past(i_index))
    else $error("post-modify address is not the index");

  a_pre_noupd: assert property ( // [RULE_04]
    i_valid && !i_instr.u |=> !o_idx_upd.valid)
    else $error("pre-modify wrote the index");

  a_y_short: assert property ( // [RULE_06]
    ex && ey && size == SZ_SW && !bcast
    |=> o_mem_y.addr == o_mem_x.addr + 32'h2)
    else $error("short second address offset wrong");

  a_y_bcast: assert property ( // [RULE_07]
    ex && ey && bcast |=> o_mem_y.addr == o_mem_x.addr)
    else $error("broadcast read offset not zero");

  a_space_irq: assert property ( // [RULE_14]
    i_valid && space_bad
    |=> !o_mem_x.valid && !o_mem_y.valid && state.status[EV_SPACE])
    else $error("sub-word outside byte space not trapped");

  a_byte_store: assert property ( // [RULE_11]
    o_mem_x.valid && o_mem_x.wr && o_mem_x.be == BE_BYTE
    |-> o_mem_x.wdata[31:8] == 24'h0)
    else $error("byte store carries upper bits");

  a_load_back: assert property ( // [RULE_15]
    s_load_issue |-> s_load_back)
    else $error("load write-back missing or not justified");

  a_scaled_upd: assert property ( // [RULE_17]
    go && i_instr.u && size == SZ_SW && cx
    |=> o_idx_upd.value
        == $past(i_index) + {$past(imm_s[30:0]), 1'b0})
    else $error("short index update not scaled");

  sequence s_y_issue;
    ey && !i_instr.d;
  endsequence

  sequence s_y_back;
    ##3 o_wb_y.valid && o_wb_y.dreg == $past(i_instr.dreg, 3);
  endsequence

  sequence s_short_load;
    ex && !i_instr.d && size == SZ_SW;
  endsequence

  sequence s_short_lanes;
    ##3 o_wb_x.valid
    && o_wb_x.data[23:16] == $past(i_mem_rd_x[15:8])
    && o_wb_x.data[15:8] == $past(i_mem_rd_x[7:0]);
  endsequence

  sequence s_byte_zload;
    ex && !i_instr.d && size == SZ_BW && !sext;
  endsequence

  a_x_route: assert property ( // [RULE_01]
    ex |=> o_mem_x.pm == $past(i_instr.g)
           && o_mem_x.wr == $past(i_instr.d))
    else $error("first element bus or direction wrong");

  a_pre_addr: assert property ( // [RULE_03]
    ex && !i_instr.u && size == SZ_NW
    |=> o_mem_x.addr == $past(i_index) + $past(imm_s))
    else $error("pre-modify address is not index plus immediate");

  a_post_upd: assert property ( // [RULE_03]
    ex && i_instr.u && size == SZ_NW
    |=> o_idx_upd.valid && o_idx_upd.value == $past(i_index) + $past(imm_s))
    else $error("post-modify index not written back");

  a_y_simd: assert property ( // [RULE_05]
    i_valid && !i_simd |=> !o_mem_y.valid && !o_comp_y)
    else $error("second element acted outside SIMD mode");

  a_y_cond: assert property ( // [RULE_18]
    i_valid && i_instr.cond != COND_ALWAYS
    && i_arith_status_second_pe[i_instr.cond[3:0]] == i_instr.cond[4]
    |=> !o_mem_y.valid)
    else $error("second element ignored its own condition");

  a_y_normal: assert property ( // [RULE_06]
    ex && ey && size == SZ_NW && !bcast
    |=> o_mem_y.addr == o_mem_x.addr + 32'h1)
    else $error("normal second address offset wrong");

  a_y_byte: assert property ( // [RULE_06]
    ex && ey && size == SZ_BW && !bcast
    |=> o_mem_y.addr == o_mem_x.addr + 32'h4)
    else $error("byte second address offset wrong");

  a_y_load: assert property ( // [RULE_08]
    s_y_issue |-> s_y_back)
    else $error("second element load target wrong");

  a_comp_none: assert property ( // [RULE_09] [RULE_10]
    i_valid && i_instr.form != FORM_4A |=> !o_comp_x && !o_comp_y)
    else $error("compute raised outside compute form");

  a_comp_par: assert property ( // [RULE_09]
    ex && i_instr.form == FORM_4A |=> o_comp_x && o_mem_x.valid)
    else $error("compute not beside the access");

  a_byte_zext: assert property ( // [RULE_11]
    s_byte_zload |-> ##3 o_wb_x.valid && o_wb_x.data[39:16] == 24'h0)
    else $error("byte load not zero-extended");

  a_short_store: assert property ( // [RULE_12]
    o_mem_x.valid && o_mem_x.wr && o_mem_x.be == BE_SHORT
    |-> o_mem_x.wdata[31:16] == 16'h0)
    else $error("short store carries upper bits");

  a_sext_store: assert property ( // [RULE_13] [RULE_19]
    i_valid && i_instr.d && sub && i_instr.opt[1]
    |=> !o_mem_x.valid && !o_mem_y.valid && state.status[EV_OPT])
    else $error("sign option on store not refused");

  a_short_sext: assert property ( // [RULE_13]
    ex && !i_instr.d && size == SZ_SW && sext
    |-> ##3 o_wb_x.data[39:24] == {16{o_wb_x.data[23]}})
    else $error("short load sign not replicated");

  a_short_lanes: assert property ( // [RULE_16]
    s_short_load |-> s_short_lanes)
    else $error("short load byte order wrong");

  a_space_upd: assert property ( // [RULE_14]
    i_valid && space_bad |=> !o_idx_upd.valid && !o_comp_x)
    else $error("faulted access updated the index");
endmodule // idd_decode

// *** bench/idd_mem_model.sv ***
module idd_mem_model (
  input wire logic i_clk,
  input wire idd_pkg::idd_mem_t i_x,
  input wire idd_pkg::idd_mem_t i_y,
  output logic [31:0] o_x,
  output logic [31:0] o_y
);
  timeunit 1ns;
  timeprecision 1ns;
  import idd_pkg::*;
  // byte at address a is a[7:0] ^ C3, lane 0 holds the lowest address
  function automatic logic [31:0] wd(input logic [31:0] a);
    wd = {a[7:0] + 8'h03, a[7:0] + 8'h02, a[7:0] + 8'h01, a[7:0]}
      ^ 32'hC3C3_C3C3;
  endfunction
  logic [31:0] q_x = 32'h5A5A_5A5A;
  logic [31:0] q_y = 32'hA5A5_A5A5;
  // data stand only in the cycle after a read; inverse otherwise
  always @(posedge i_clk)
  begin
    q_x <= (i_x.valid && !i_x.wr) ? wd(i_x.addr) : ~q_x;
    q_y <= (i_y.valid && !i_y.wr) ? wd(i_y.addr) : ~q_y;
  end
  assign o_x = q_x;
  assign o_y = q_y;
endmodule // idd_mem_model

// *** bench/idd_decode_tb.sv ***
module idd_decode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import idd_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic valid = 1'b0;
  idd_instr_t ins = '0;
  logic [31:0] index = 32'h0;
  logic bsp = 1'b1;
  logic simd = 1'b0;
  logic bc1 = 1'b0;
  logic bc9 = 1'b0;
  logic [31:0] st_x = 32'h0;
  logic [31:0] st_y = 32'h0;
  logic [39:0] dx = 40'hAB_CDEF_1234;
  logic [39:0] dy = 40'h98_7654_5600;
  logic [31:0] rd_x;
  logic [31:0] rd_y;
  idd_regbus_t rb = '0;
  logic [31:0] reg_rdata;
  idd_mem_t mx, my, smx, smy;
  idd_idx_t iu, siu;
  idd_wb_t wx, wy, swx, swy;
  logic cx, cy, scx, scy, irq;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;

  idd_decode uut (
    .i_clk(clk),
    .i_rst_b(rst_b),
    .i_valid(valid),
    .i_instr(ins),
    .i_index(index),
    .i_byte_space(bsp),
    .i_simd(simd),
    .i_broadcast_read_first_index(bc1),
    .i_broadcast_read_ninth_index(bc9),
    .i_arith_status_first_pe(st_x),
    .i_arith_status_second_pe(st_y),
    .i_dreg_x(dx),
    .i_dreg_y(dy),
    .i_mem_rd_x(rd_x),
    .i_mem_rd_y(rd_y),
    .i_reg(rb),
    .o_reg_rdata(reg_rdata),
    .o_mem_x(mx),
    .o_mem_y(my),
    .o_idx_upd(iu),
    .o_wb_x(wx),
    .o_wb_y(wy),
    .o_comp_x(cx),
    .o_comp_y(cy),
    .o_irq(irq)
  );

  idd_mem_model mem (
    .i_clk(clk),
    .i_x(mx),
    .i_y(my),
    .o_x(rd_x),
    .o_y(rd_y)
  );

  initial
  begin
    forever #10 clk = ~clk;
  end

  function automatic logic [7:0] bv(input logic [31:0] a);
    bv = a[7:0] ^ 8'hC3;
  endfunction

  function automatic logic [31:0] wd(input logic [31:0] a);
    wd = {bv(a + 32'h3), bv(a + 32'h2), bv(a + 32'h1), bv(a)};
  endfunction

  function automatic idd_instr_t mk(input idd_form_t f,
    input logic [4:0] c, input logic [2:0] gdu, input logic [2:0] ix,
    input logic [5:0] im, input logic [2:0] op);
    mk = '{f, c, gdu[2], gdu[1], gdu[0], 4'h3, ix, im, op};
  endfunction

  task automatic finish_test;
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // a hang costs one mismatch, then the normal report
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input logic ok, input string what);
    n_tests++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic rg(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    @(posedge clk);
    rb <= '{w, !w, a, d};
    @(posedge clk);
    rb <= '0;
    #1;
  endtask

  task automatic cfg(input logic s, b1, b9, bs,
    input logic [31:0] sx, sy);
    @(posedge clk);
    simd <= s;
    bc1 <= b1;
    bc9 <= b9;
    bsp <= bs;
    st_x <= sx;
    st_y <= sy;
  endtask

  // one instruction; outputs caught one and three cycles later
  task automatic go(input idd_instr_t i, input logic [31:0] a);
    @(posedge clk);
    ins <= i;
    index <= a;
    valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    #1;
    smx = mx;
    smy = my;
    siu = iu;
    scx = cx;
    scy = cy;
    repeat (2) @(posedge clk);
    #1;
    swx = wx;
    swy = wy;
  endtask

  task automatic t_post_load;
    cfg(1'b0, 1'b0, 1'b0, 1'b1, 32'h0, 32'h0);
    go(mk(FORM_4B, 5'h1F, 3'b001, 3'h2, 6'h05, 3'b001), 32'h100);
    chk(smx.addr === 32'h100 && smx.pm === 1'b0, "pl a");
    chk(siu.valid === 1'b1 && siu.value === 32'h105, "pl i");
    chk(smy.valid === 1'b0 && scx === 1'b0, "pl y");
    chk(swx.data === {wd(32'h100), 8'h00}, "pl d");
    chk(siu.g === 1'b0 && siu.idx === 3'h2, "pl g");
    chk(swx.valid === 1'b1 && swx.dreg === 4'h3, "pl r");
  endtask

  task automatic t_pre_store;
    go(mk(FORM_4A, 5'h1F, 3'b110, 3'h2, 6'h04, 3'b001), 32'h200);
    chk(smx.addr === 32'h204 && smx.wr === 1'b1, "ps a");
    chk(smx.pm === 1'b1 && smx.be === BE_WORD, "ps b");
    chk(smx.wdata === 32'hABCD_EF12 && scx === 1'b1, "ps d");
    chk(siu.valid === 1'b0 && swx.valid === 1'b0, "ps i");
  endtask

  task automatic t_cond;
    cfg(1'b1, 1'b0, 1'b0, 1'b1, 32'h8, 32'h0);
    go(mk(FORM_4B, 5'h03, 3'b001, 3'h2, 6'h01, 3'b001), 32'h300);
    chk(smx.valid === 1'b1 && smy.valid === 1'b0, "c x");
    cfg(1'b1, 1'b0, 1'b0, 1'b1, 32'h0, 32'h8);
    go(mk(FORM_4B, 5'h03, 3'b001, 3'h2, 6'h01, 3'b001), 32'h300);
    chk(smx.valid === 1'b0 && smy.valid === 1'b1, "c y");
    chk(smy.addr === 32'h301, "c k");
    chk(swy.data === {wd(32'h301), 8'h00}, "c w");
    chk(swy.valid === 1'b1 && swy.dreg === 4'h3, "c r");
    cfg(1'b1, 1'b0, 1'b0, 1'b1, 32'h8, 32'h8);
    go(mk(FORM_4B, 5'h13, 3'b001, 3'h2, 6'h01, 3'b001), 32'h300);
    chk(smx.valid === 1'b0 && smy.valid === 1'b0, "c f");
    chk(siu.valid === 1'b0, "c i");
  endtask

  task automatic t_short;
    logic [15:0] s;
    logic [15:0] t;
    cfg(1'b1, 1'b0, 1'b0, 1'b1, 32'h0, 32'h0);
    go(mk(FORM_4D, 5'h1F, 3'b001, 3'h2, 6'h02, 3'b110), 32'h400);
    s = {bv(32'h401), bv(32'h400)};
    t = {bv(32'h403), bv(32'h402)};
    chk(smy.addr === 32'h402 && smx.be === BE_SHORT, "s k");
    chk(siu.value === 32'h404, "s i");
    chk(swx.data === {{16{s[15]}}, s, 8'h00}, "sx");
    chk(swy.data === {{16{t[15]}}, t, 8'h00}, "sy");
    go(mk(FORM_4B, 5'h1F, 3'b001, 3'h2, 6'h02, 3'b100), 32'h400);
    chk(swx.data === {16'h0, s, 8'h00}, "zx");
  endtask

  task automatic t_byte;
    go(mk(FORM_4D, 5'h1F, 3'b011, 3'h2, 6'h03, 3'b000), 32'h500);
    chk(smx.be === BE_BYTE && smx.wdata[7:0] === 8'h12, "b x");
    chk(smy.addr === 32'h504 && smy.wdata[7:0] === 8'h56, "b y");
    chk(siu.value === 32'h503, "b i");
    chk(smy.wr === 1'b1 && smy.be === BE_BYTE, "b w");
    go(mk(FORM_4D, 5'h1F, 3'b011, 3'h2, 6'h01, 3'b100), 32'h520);
    chk(smx.wdata === 32'h0000_EF12 && smx.be === BE_SHORT, "sw");
    chk(siu.value === 32'h522, "sw i");
    go(mk(FORM_4D, 5'h1F, 3'b001, 3'h2, 6'h01, 3'b000), 32'h510);
    chk(swx.data === {24'h0, bv(32'h510), 8'h00}, "bz");
  endtask

  task automatic t_bcast;
    cfg(1'b1, 1'b1, 1'b0, 1'b1, 32'h0, 32'h0);
    go(mk(FORM_4A, 5'h1F, 3'b001, 3'h1, 6'h01, 3'b001), 32'h700);
    chk(smy.valid === 1'b1 && smy.addr === 32'h700, "bc1");
    go(mk(FORM_4A, 5'h1F, 3'b101, 3'h1, 6'h01, 3'b001), 32'h700);
    chk(smy.addr === 32'h701, "bcg");
    cfg(1'b1, 1'b0, 1'b1, 1'b1, 32'h0, 32'h0);
    go(mk(FORM_4A, 5'h1F, 3'b101, 3'h1, 6'h01, 3'b001), 32'h700);
    chk(smy.addr === 32'h700 && smy.pm === 1'b1, "bc9");
    chk(scx === 1'b1 && scy === 1'b1, "cmp");
  endtask

  task automatic t_fault;
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 32'h0);
    go(mk(FORM_4D, 5'h1F, 3'b001, 3'h2, 6'h01, 3'b100), 32'h600);
    chk(smx.valid === 1'b0 && siu.valid === 1'b0, "sp");
    chk(irq === 1'b0, "msk");
    rg(1'b1, REG_MASK, 32'h3);
    rg(1'b0, REG_STATUS, 32'h0);
    chk(reg_rdata[0] === 1'b1 && irq === 1'b1, "irq");
    cfg(1'b0, 1'b0, 1'b0, 1'b1, 32'h0, 32'h0);
    go(mk(FORM_4D, 5'h1F, 3'b011, 3'h2, 6'h01, 3'b010), 32'h600);
    chk(smx.valid === 1'b0, "se");
    rg(1'b0, REG_STATUS, 32'h0);
    chk(reg_rdata === 32'h7, "st1");
    rg(1'b1, REG_STATUS, 32'h7);
    rg(1'b0, REG_STATUS, 32'h0);
    chk(reg_rdata === 32'h0 && irq === 1'b0, "clr");
    rg(1'b0, REG_MASK, 32'h0);
    chk(reg_rdata === 32'h3, "mrd");
    rg(1'b0, 4'h8, 32'h0);
    chk(reg_rdata === 32'h0, "unm");
    // a fault and a write-one clear in the same cycle: the fault stays
    @(posedge clk);
    ins <= mk(FORM_4D, 5'h1F, 3'b011, 3'h2, 6'h01, 3'b010);
    valid <= 1'b1;
    rb <= '{1'b1, 1'b0, REG_STATUS, 32'h7};
    @(posedge clk);
    valid <= 1'b0;
    rb <= '0;
    rg(1'b0, REG_STATUS, 32'h0);
    chk(reg_rdata === 32'h2, "set");
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rg(1'b0, REG_STATUS, 32'h0);
    chk(reg_rdata === 32'h0, "rst s");
    rg(1'b0, REG_MASK, 32'h0);
    chk(reg_rdata === 32'h0, "rst m");
    t_post_load();
    t_pre_store();
    t_cond();
    t_short();
    t_byte();
    t_bcast();
    t_fault();
    finish_test();
  end
endmodule // idd_decode_tb
